// file: rtl/fbo_pkg.sv
// package: pin levels, operation codes and timing for the flash bus host
package fbo_pkg;
  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int SECT_LSB = 16;
  // ----------------------------------------------------------------
  // protect address pattern
  // ----------------------------------------------------------------
  localparam int PROT_A6 = 6;
  localparam int PROT_A1 = 1;
  localparam int PROT_A0 = 0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int ACC_NS = 120;
  localparam int WR_NS = 50;
  localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC = (WR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] ACC_CNT = 4'(ACC_CYC);
  localparam logic [3:0] WR_CNT = 4'(WR_CYC);
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_PROTECT,
    OP_UNPROTECT,
    OP_RESET
  } fbo_op_e;

  typedef struct packed {
    fbo_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fbo_req_s;

  typedef struct packed {
    logic selN;
    logic gateN;
    logic strobeN;
    logic clearN;
    logic highVolt;
  } fbo_ctl_s;
endpackage : fbo_pkg

// file: rtl/fbo_sync.sv
// two-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module fbo_sync #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          stage1[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          stage1[i] <= din[i];
          dout[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule : fbo_sync
`default_nettype wire

// file: rtl/fbo_host.sv
// host controller driving the flash bus pins
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - reads drive select low, gate low, strobe high; data sampled.
// - writes drive strobe and select low with gate high.
// - protect needs high voltage clear, pattern A6 low A1 high A0 low.
module fbo_host #(
  parameter logic [3:0] ACC = fbo_pkg::ACC_CNT,
  parameter logic [3:0] WR = fbo_pkg::WR_CNT
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire fbo_pkg::fbo_req_s req,
  input wire logic reqValid,
  output logic reqReady,
  output logic [fbo_pkg::DATA_W-1:0] rdData,
  output logic rdValid,
  output fbo_pkg::fbo_ctl_s ctl,
  output logic [fbo_pkg::ADDR_W-1:0] addressLines,
  output logic [fbo_pkg::DATA_W-1:0] dataLinesOut,
  output logic dataLinesOe,
  input wire logic [fbo_pkg::DATA_W-1:0] dataLinesIn
);
  import fbo_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum {S_IDLE, S_RD, S_WR, S_RST, S_REL} fbo_state_e;
  fbo_state_e state;
  fbo_state_e next_state;
  logic [3:0] cnt;
  logic [DATA_W-1:0] syncData;
  fbo_op_e curOp;

  fbo_sync #(.W(DATA_W)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din(dataLinesIn),
    .dout(syncData)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire take = reqReady && reqValid;
  wire cntDone = (cnt == 4'h0);
  wire isRead = (req.op == OP_READ);
  wire isRst = (req.op == OP_RESET);
  wire isProt = (req.op == OP_PROTECT) || (req.op == OP_UNPROTECT);
  // pattern forced on protect operations
  wire [ADDR_W-1:0] protAddr = {req.addr[ADDR_W-1:PROT_A6+1],
    (req.op == OP_UNPROTECT), req.addr[PROT_A6-1:PROT_A1+1],
    1'b1, 1'b0};
  wire [ADDR_W-1:0] useAddr = isProt ? protAddr : req.addr;

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (take) begin
          if (isRst) next_state = S_RST;
          else if (isRead) next_state = S_RD;
          else next_state = S_WR;
        end
      end
      S_RD: if (cntDone) next_state = S_REL;
      S_WR: if (cntDone) next_state = S_REL;
      S_RST: if (cntDone) next_state = S_REL;
      S_REL: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= S_RST;
      cnt <= WR;
      curOp <= OP_RESET;
      reqReady <= 1'b0;
      rdValid <= 1'b0;
      rdData <= 8'h00;
      ctl <= '{selN: 1'b1, gateN: 1'b1, strobeN: 1'b1, clearN: 1'b0,
        highVolt: 1'b0};
      addressLines <= 20'h00000;
      dataLinesOut <= 8'h00;
      dataLinesOe <= 1'b1;
    end else begin
      state <= next_state;
      rdValid <= 1'b0;
      cnt <= cntDone ? 4'h0 : cnt - 4'h1;
      case (state)
        S_IDLE: begin
          if (take) begin
            curOp <= req.op;
            reqReady <= 1'b0;
            addressLines <= useAddr;
            if (isRst) begin
              cnt <= WR;
              ctl.clearN <= 1'b0;
            end else if (isRead) begin
              cnt <= ACC + 4'h2;
              ctl.selN <= 1'b0;
              ctl.gateN <= 1'b0;
            end else begin
              cnt <= WR;
              ctl.selN <= 1'b0;
              ctl.strobeN <= 1'b0;
              ctl.highVolt <= isProt;
              dataLinesOut <= req.data;
              dataLinesOe <= 1'b0;
            end
          end else begin
            reqReady <= 1'b1;
          end
        end
        S_RD: if (cntDone) begin
          rdData <= syncData;
          rdValid <= 1'b1;
          ctl.gateN <= 1'b1;
          ctl.selN <= 1'b1;
        end
        S_WR: if (cntDone) begin
          ctl.strobeN <= 1'b1;
          ctl.selN <= 1'b1;
        end
        S_RST: if (cntDone) ctl.clearN <= 1'b1;
        S_REL: begin
          dataLinesOe <= 1'b1;
          ctl.highVolt <= 1'b0;
          reqReady <= 1'b1;
        end
        default: reqReady <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence rdStart_q;
    take && isRead;
  endsequence

  read_pins_a: assert property (ctl.gateN == 1'b0 |->
    ctl.selN == 1'b0 && ctl.strobeN)
    else $error("read without select or with strobe");
  write_pins_a: assert property (ctl.strobeN == 1'b0 |->
    ctl.selN == 1'b0 && ctl.gateN)
    else $error("write pin levels wrong");
  no_contend_a: assert property (!dataLinesOe |-> ctl.gateN)
    else $error("host drives data while gate low");
  read_done_a: assert property (rdStart_q |-> ##[3:20] rdValid)
    else $error("read did not complete");
  sel_strobe_a: assert property (ctl.selN |-> ctl.strobeN)
    else $error("strobe active while deselected");
  prot_pat_a: assert property (ctl.highVolt |->
    addressLines[PROT_A1] && !addressLines[PROT_A0])
    else $error("protect address pattern wrong");
  clr_idle_a: assert property (!ctl.clearN |->
    ctl.selN && !reqReady)
    else $error("activity during clear");
  rel_sel_a: assert property ($rose(ctl.selN) |->
    ##[1:2] dataLinesOe)
    else $error("bus not released after cycle");
endmodule : fbo_host
`default_nettype wire

// file: tb/fbo_flash_model.sv
// behavioural byte-wide flash device facing the host pins
`timescale 1ns/1ps
`default_nettype none
module fbo_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5a // arbitrary value
) (
  input wire fbo_pkg::fbo_ctl_s ctl,
  input wire logic [fbo_pkg::ADDR_W-1:0] addressLines,
  input wire logic [fbo_pkg::DATA_W-1:0] dataLinesOut,
  output wire logic [fbo_pkg::DATA_W-1:0] dataLinesIn,
  output logic [fbo_pkg::ADDR_W-1:0] lastAddr,
  output logic lastHv
);
  import fbo_pkg::*;
  logic [7:0] mem [256];
  logic idMode = 1'b0;
  logic [7:0] hold = 8'h00;
  wire drive = !ctl.selN && !ctl.gateN && ctl.clearN;
  wire [7:0] rdVal = idMode ? ID_CODE : mem[addressLines[7:0]];
  // released bus shows the inverse of the last value
  assign dataLinesIn = drive ? rdVal : ~hold;
  always @(negedge drive) hold = rdVal;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    lastAddr = '0;
    lastHv = 1'b0;
  end
  always @(negedge ctl.clearN) idMode = 1'b0;
  always @(negedge ctl.strobeN) begin
    // let the data and voltage launched on the same edge settle
    #1;
    if (!ctl.selN && (ctl.clearN || ctl.highVolt)) begin
      lastAddr = addressLines;
      lastHv = ctl.highVolt;
      if (ctl.highVolt) ;
      else if (dataLinesOut == 8'h90) idMode = 1'b1;
      else if (dataLinesOut == 8'hf0) idMode = 1'b0;
      else mem[addressLines[7:0]] = dataLinesOut;
    end
  end
endmodule : fbo_flash_model
`default_nettype wire

// file: tb/fbo_host_test.sv
// self-checking bench for the flash bus host
`timescale 1ns/1ps
`default_nettype none
module fbo_host_test;
  import fbo_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, reqValid = 1'b0;
  fbo_req_s req = '0;
  logic reqReady, rdValid, dataLinesOe, lastHv;
  logic [7:0] rdData, dataLinesOut, dataLinesIn;
  logic [19:0] addressLines, lastAddr;
  fbo_ctl_s ctl;
  int bad_count = 0, num_checks = 0;
  fbo_host dut (.mclk(mclk), .sys_rst(sys_rst), .req(req),
    .reqValid(reqValid), .reqReady(reqReady), .rdData(rdData),
    .rdValid(rdValid), .ctl(ctl), .addressLines(addressLines),
    .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe),
    .dataLinesIn(dataLinesIn));
  fbo_flash_model dev (.ctl(ctl), .addressLines(addressLines),
    .dataLinesOut(dataLinesOut), .dataLinesIn(dataLinesIn),
    .lastAddr(lastAddr), .lastHv(lastHv));
  initial forever #10 mclk = ~mclk;
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task chk(input logic [19:0] seen, input logic [19:0] exp, input string m);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task issue(input fbo_op_e op, input logic [19:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    while (reqReady !== 1'b1) begin
      if (++n > 60) begin
        bad_count++;
        conclude();
      end
      @(negedge mclk);
    end
    @(negedge mclk);
    req = '{op, a, d};
    reqValid = 1'b1;
    // ready stands high in idle, so the next rising edge takes it
    @(negedge mclk);
    chk(20'(reqReady), 20'h0, "request not taken");
    reqValid = 1'b0;
  endtask : issue
  task readAt(input logic [19:0] a, input logic [7:0] exp, input string m);
    int n;
    n = 0;
    issue(OP_READ, a, 8'h00);
    while (rdValid !== 1'b1) begin
      if (++n > 40) begin
        bad_count++;
        conclude();
      end
      @(posedge mclk);
      #1;
    end
    chk(20'(rdData), 20'(exp), m);
  endtask : readAt
  // pin relations seen on every falling edge
  always @(negedge mclk) begin
    if (!sys_rst && ctl.strobeN === 1'b0)
      chk(20'({ctl.gateN, ctl.selN}), 20'h2, "write pins");
    if (!sys_rst && ctl.gateN === 1'b0)
      chk(20'({ctl.strobeN, dataLinesOe}), 20'h3, "read pins");
  end
  task tArray;
    issue(OP_WRITE, 20'h12345, 8'h3c);
    readAt(20'h12345, 8'h3c, "array readback");
  endtask : tArray
  task tIdent;
    issue(OP_WRITE, 20'hab001, 8'h90);
    readAt(20'h00045, 8'h5a, "ident code");
    issue(OP_WRITE, 20'h00000, 8'hf0);
    readAt(20'h12345, 8'h3c, "back to array");
  endtask : tIdent
  task tProtect;
    issue(OP_PROTECT, 20'hf00c5, 8'h00);
    repeat (4) @(negedge mclk);
    chk(lastAddr, 20'hf0086, "protect address");
    chk(20'(lastHv), 20'h1, "protect voltage");
    issue(OP_UNPROTECT, 20'h70000, 8'h00);
    repeat (4) @(negedge mclk);
    chk(lastAddr, 20'h70042, "unprotect address");
    chk(20'(lastHv), 20'h1, "unprotect voltage");
  endtask : tProtect
  task tReset;
    issue(OP_WRITE, 20'h00001, 8'h90);
    issue(OP_RESET, 20'h00000, 8'h00);
    readAt(20'h12345, 8'h3c, "read after clear");
  endtask : tReset
  initial begin
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    tArray();
    tIdent();
    tProtect();
    tReset();
    conclude();
  end
endmodule : fbo_host_test
`default_nettype wire
